/* File: logic/tpio_pkg.sv */
package tpio_pkg;

	// Port widths and alternate pin positions
	localparam int P0_WIDTH = 5;
	localparam int P1_WIDTH = 8;
	localparam int P3_WIDTH = 8;
	localparam int ADC_CHANNELS = 5;
	localparam int PWM_PIN = 4;
	localparam int OD_PINS = 3;
	localparam int IRQ0_PIN = 5;
	localparam int IRQ1_PIN = 6;
	localparam int T0_PIN = 7;

	// Register byte offsets
	localparam logic [7:0] OFS_P0_LATCH = 8'h00;
	localparam logic [7:0] OFS_P1_LATCH = 8'h04;
	localparam logic [7:0] OFS_P3_LATCH = 8'h08;
	localparam logic [7:0] OFS_P0_PINS = 8'h0c;
	localparam logic [7:0] OFS_P1_PINS = 8'h10;
	localparam logic [7:0] OFS_P3_PINS = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;

	// Reset values
	localparam logic [7:0] LATCH_RST = 8'hff;
	localparam logic [4:0] CTRL_RST = 5'h00;

	// Control field positions
	localparam int CTRL_PWM_BIT = 0;
	localparam int CTRL_ADC_BIT = 1;
	localparam int CTRL_SEL_LSB = 2;
	localparam int CTRL_SEL_W = 3;

	// Bus encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// Control register contents, pwm_en is bit 0
	typedef struct packed {
		logic [CTRL_SEL_W-1:0] adc_sel;
		logic adc_en;
		logic pwm_en;
	} tpio_ctrl_t;

	// Captured address phase
	typedef struct packed {
		logic act;
		logic wr;
		logic [2:0] idx;
	} tpio_aphase_t;

	// Register index
	typedef enum logic [2:0] {
		REG_P0_LATCH = 3'h0,
		REG_P1_LATCH = 3'h1,
		REG_P3_LATCH = 3'h2,
		REG_P0_PINS = 3'h3,
		REG_P1_PINS = 3'h4,
		REG_P3_PINS = 3'h5,
		REG_CTRL = 3'h6,
		REG_NONE = 3'h7
	} tpio_reg_t;

endpackage

/* File: logic/tpio_gpio.sv */
`timescale 1ns/100ps
module tpio_gpio
	import tpio_pkg::*;
#(
	parameter int P0_W = P0_WIDTH,
	parameter int P1_W = P1_WIDTH,
	parameter int P3_W = P3_WIDTH
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Port 0 pins
	input wire logic [P0_W-1:0] p0_pin_in,
	output logic [P0_W-1:0] p0_pin_out,
	output logic [P0_W-1:0] p0_pin_oe_out,
	// Port 1 pins
	input wire logic [P1_W-1:0] p1_pin_in,
	output logic [P1_W-1:0] p1_pin_out,
	output logic [P1_W-1:0] p1_pin_oe_out,
	// Port 3 pins
	input wire logic [P3_W-1:0] p3_pin_in,
	output logic [P3_W-1:0] p3_pin_out,
	output logic [P3_W-1:0] p3_pin_oe_out,
	// PWM generator, same clock
	input wire logic pwm_wave_in,
	// Alternate functions towards core
	output logic ext_irq0_input_out,
	output logic ext_irq1_input_out,
	output logic timer0_count_input_out,
	output logic adc_enable_out,
	output logic [CTRL_SEL_W-1:0] adc_select_out
);

	// Bus and register state
	tpio_aphase_t aph_q;
	tpio_ctrl_t ctrl_q;
	tpio_ctrl_t ctrl_d;
	logic [P0_W-1:0] lat0_q;
	logic [P0_W-1:0] lat0_d;
	logic [P1_W-1:0] lat1_q;
	logic [P1_W-1:0] lat1_d;
	logic [P3_W-1:0] lat3_q;
	logic [P3_W-1:0] lat3_d;

	// Pin synchronisers
	logic [P0_W-1:0] p0_s1_q;
	logic [P0_W-1:0] p0_s2_q;
	logic [P1_W-1:0] p1_s1_q;
	logic [P1_W-1:0] p1_s2_q;
	logic [P3_W-1:0] p3_s1_q;
	logic [P3_W-1:0] p3_s2_q;

	// Derived values
	logic [P1_W-1:0] p1_rd;
	logic [P0_W-1:0] p0_oe_d;
	logic [P0_W-1:0] p0_out_d;
	logic [P1_W-1:0] p1_oe_d;
	logic [P3_W-1:0] p3_oe_d;
	logic take;
	logic wr_dp;
	logic [31:0] rd_d;
	tpio_reg_t rd_idx;

	// Map a byte address to a register index
	function automatic tpio_reg_t decode(input logic [31:0] a);
		tpio_reg_t r;
		r = REG_NONE;
		if (a[31:8] == 24'h000000) begin
			case (a[7:0])
				OFS_P0_LATCH: r = REG_P0_LATCH;
				OFS_P1_LATCH: r = REG_P1_LATCH;
				OFS_P3_LATCH: r = REG_P3_LATCH;
				OFS_P0_PINS: r = REG_P0_PINS;
				OFS_P1_PINS: r = REG_P1_PINS;
				OFS_P3_PINS: r = REG_P3_PINS;
				OFS_CTRL: r = REG_CTRL;
				default: r = REG_NONE;
			endcase
		end
		return r;
	endfunction

	// Address phase accepted for any size; only word transfers decode to a register
	assign take = hsel_in && hready_in && htrans_in[1];
	assign rd_idx = (hsize_in == HSIZE_WORD) ? decode(haddr_in) : REG_NONE;
	assign wr_dp = aph_q.act && aph_q.wr;

	// Capture the address phase
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			aph_q <= '0;
		end else begin
			aph_q.act <= take;
			aph_q.wr <= hwrite_in;
			aph_q.idx <= rd_idx;
		end
	end

	// Next latch and control values from the write data phase
	always_comb begin
		lat0_d = lat0_q;
		lat1_d = lat1_q;
		lat3_d = lat3_q;
		ctrl_d = ctrl_q;
		if (wr_dp) begin
			case (tpio_reg_t'(aph_q.idx))
				REG_P0_LATCH: lat0_d = hwdata_in[P0_W-1:0];
				REG_P1_LATCH: lat1_d = hwdata_in[P1_W-1:0];
				REG_P3_LATCH: lat3_d = hwdata_in[P3_W-1:0];
				REG_CTRL: ctrl_d = hwdata_in[$bits(tpio_ctrl_t)-1:0];
				default: ctrl_d = ctrl_q;
			endcase
		end
	end

	// Output latches, all ones after reset so every pin is released
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			lat0_q <= LATCH_RST[P0_W-1:0];
			lat1_q <= LATCH_RST[P1_W-1:0];
			lat3_q <= LATCH_RST[P3_W-1:0];
		end else begin
			lat0_q <= lat0_d;
			lat1_q <= lat1_d;
			lat3_q <= lat3_d;
		end
	end

	// Control register and its copies for the converter
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ctrl_q <= CTRL_RST;
			adc_enable_out <= 1'b0;
			adc_select_out <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			adc_enable_out <= ctrl_d.adc_en;
			adc_select_out <= ctrl_d.adc_sel;
		end
	end

	// Two-flop synchronisers on every pin
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			p0_s1_q <= '1;
			p0_s2_q <= '1;
			p1_s1_q <= '1;
			p1_s2_q <= '1;
			p3_s1_q <= '1;
			p3_s2_q <= '1;
		end else begin
			p0_s1_q <= p0_pin_in;
			p0_s2_q <= p0_s1_q;
			p1_s1_q <= p1_pin_in;
			p1_s2_q <= p1_s1_q;
			p3_s1_q <= p3_pin_in;
			p3_s2_q <= p3_s1_q;
		end
	end

	// Port 1 read value; the channel under conversion reads zero
	always_comb begin
		p1_rd = p1_s2_q;
		for (int i = 0; i < ADC_CHANNELS; i++) begin
			if (ctrl_q.adc_en && (ctrl_q.adc_sel == i[CTRL_SEL_W-1:0])) begin
				p1_rd[i] = 1'b0;
			end
		end
	end

	// Alternate inputs follow the synchronised pins
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ext_irq0_input_out <= 1'b1;
			ext_irq1_input_out <= 1'b1;
			timer0_count_input_out <= 1'b1;
		end else begin
			ext_irq0_input_out <= p1_s2_q[IRQ0_PIN];
			ext_irq1_input_out <= p1_s2_q[IRQ1_PIN];
			timer0_count_input_out <= p1_s2_q[T0_PIN];
		end
	end

	// Pin drive: a zero latch pulls low, a one releases to pull-up or float; PWM drives P0.4, the converter releases P1.0-P1.4
	always_comb begin
		p0_oe_d = ~lat0_q;
		p0_out_d = '0;
		if (ctrl_q.pwm_en) begin
			p0_oe_d[PWM_PIN] = 1'b1;
			p0_out_d[PWM_PIN] = pwm_wave_in;
		end
		p1_oe_d = ~lat1_q;
		if (ctrl_q.adc_en) begin
			p1_oe_d[ADC_CHANNELS-1:0] = '0;
		end
		p3_oe_d = ~lat3_q;
	end

	// Registered pin drivers
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			p0_pin_out <= '0;
			p0_pin_oe_out <= '0;
			p1_pin_out <= '0;
			p1_pin_oe_out <= '0;
			p3_pin_out <= '0;
			p3_pin_oe_out <= '0;
		end else begin
			p0_pin_out <= p0_out_d;
			p0_pin_oe_out <= p0_oe_d;
			p1_pin_out <= '0;
			p1_pin_oe_out <= p1_oe_d;
			p3_pin_out <= '0;
			p3_pin_oe_out <= p3_oe_d;
		end
	end

	// Read mux; latch values include a write finishing this cycle
	always_comb begin
		rd_d = RD_ZERO;
		case (rd_idx)
			REG_P0_LATCH: rd_d[P0_W-1:0] = lat0_d;
			REG_P1_LATCH: rd_d[P1_W-1:0] = lat1_d;
			REG_P3_LATCH: rd_d[P3_W-1:0] = lat3_d;
			REG_P0_PINS: rd_d[P0_W-1:0] = p0_s2_q;
			REG_P1_PINS: rd_d[P1_W-1:0] = p1_rd;
			REG_P3_PINS: rd_d[P3_W-1:0] = p3_s2_q;
			REG_CTRL: rd_d[$bits(tpio_ctrl_t)-1:0] = ctrl_d;
			default: rd_d = RD_ZERO;
		endcase
	end

	// Bus answer: zero wait states, always OKAY
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			hrdata_out <= RD_ZERO;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hrdata_out <= (take && !hwrite_in) ? rd_d : RD_ZERO;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// Checks on the design's own outputs
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	// Open-drain bits never drive high
	a_open_drain_low: assert property (
		p0_pin_out[OD_PINS-1:0] == '0)
		else $error("Port 0 open-drain bit drove high");

	// Without PWM no port 0 bit is driven high
	a_p0_out_idle: assert property (
		!$past(ctrl_q.pwm_en) |-> p0_pin_out == '0)
		else $error("Port 0 drove a pin high without PWM");

	// PWM wave reaches P0.4 one cycle later
	a_pwm_on_pin: assert property (
		ctrl_q.pwm_en && !$past(sys_rst_in)
		|=> p0_pin_oe_out[PWM_PIN] && p0_pin_out[PWM_PIN] == $past(pwm_wave_in))
		else $error("PWM wave missing on P0.4");

	// Without PWM P0.4 follows its latch
	a_p04_latch: assert property (
		!ctrl_q.pwm_en |=> p0_pin_oe_out[PWM_PIN] == !$past(lat0_q[PWM_PIN]))
		else $error("P0.4 not driven by its latch");

	// Analog pins float while converting
	a_analog_float: assert property (
		ctrl_q.adc_en |=> p1_pin_oe_out[ADC_CHANNELS-1:0] == '0)
		else $error("Analog pin driven while converter on");

	// Selected channel returns zero on a port 1 pin read
	a_sel_reads_zero: assert property (
		take && !hwrite_in && rd_idx == REG_P1_PINS && ctrl_q.adc_en
		&& ctrl_q.adc_sel < ADC_CHANNELS
		|=> hrdata_out[$past(ctrl_q.adc_sel)] == 1'b0)
		else $error("Selected analog channel read as digital");

	// Upper port 1 bits stay ordinary I/O
	a_p1_gpio_bits: assert property (
		##1 p1_pin_oe_out[P1_W-1:ADC_CHANNELS] == ~$past(lat1_q[P1_W-1:ADC_CHANNELS]))
		else $error("P1.5-P1.7 drive not from latch");

	// A one in a port 3 latch releases the pin to its pull-up
	a_p3_released: assert property (
		lat3_q == '1 |=> p3_pin_oe_out == '0)
		else $error("Port 3 pin driven with latch one");

	// Interrupt input follows the pin after three edges
	a_irq0_path: assert property (
		!$past(sys_rst_in, 3) |-> ext_irq0_input_out == $past(p1_pin_in[IRQ0_PIN], 3))
		else $error("External interrupt 0 path delay wrong");

	// A written latch value appears on the pins two edges later
	a_latch_to_pin: assert property (
		wr_dp && aph_q.idx == REG_P3_LATCH
		|=> ##1 p3_pin_oe_out == ~$past(hwdata_in[P3_W-1:0], 2))
		else $error("Port 3 latch write lost");

	// Bus answers at once and never errors
	a_bus_okay: assert property (
		hreadyout_out && !hresp_out)
		else $error("Slave stalled or answered ERROR");

	// Upper port 1 bits read their pins whatever the converter does
	a_p1_read_upper: assert property (
		take && !hwrite_in && rd_idx == REG_P1_PINS
		|=> hrdata_out[P1_W-1:ADC_CHANNELS] == $past(p1_s2_q[P1_W-1:ADC_CHANNELS]))
		else $error("P1.5-P1.7 read not from pins");

	// Converter copies match the control register
	a_adc_copy: assert property (
		adc_enable_out == ctrl_q.adc_en && adc_select_out == ctrl_q.adc_sel)
		else $error("Converter enable or select out of step");

endmodule

/* File: sim/tpio_board.sv */
`timescale 1ns/100ps
// Board side of all 21 pins, ordered {port 3, port 1, port 0}
module tpio_board #(
	parameter logic [20:0] PULL = 21'h1ffff8
) (
	// Clock
	input wire logic ref_clk_in,
	// Device drive
	input wire logic [20:0] dev_oe_in,
	input wire logic [20:0] dev_out_in,
	// Board drivers
	input wire logic [20:0] ext_en_in,
	input wire logic [20:0] ext_val_in,
	// Resolved wire levels
	output logic [20:0] pin_out
);
	logic flip_q = 1'b0;
	// A floating open-drain line must not look like a stable level
	always @(posedge ref_clk_in) flip_q <= ~flip_q;
	// Device drive wins, then a board driver, then the pull-up
	always_comb begin
		for (int i = 0; i < 21; i++) begin
			pin_out[i] = dev_oe_in[i] ? dev_out_in[i] : ext_en_in[i] ? ext_val_in[i] : PULL[i] ? 1'b1 : flip_q;
		end
	end
endmodule

/* File: sim/tpio_gpio_test.sv */
`timescale 1ns/100ps
module tpio_gpio_test;
	import tpio_pkg::*;
	logic ref_clk_in = 0, sys_rst_in = 1, hsel = 0, hwrite = 0, pwm = 0, hready, hresp, irq0, irq1, t0, adc_en;
	logic [1:0] htrans = 0;
	logic [2:0] adc_sel, hsz = HSIZE_WORD;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [20:0] oe, dout, pin, ext_en = '1, ext_val = 0, l, e;
	int err_total = 0, num_checks = 0, cyc = 0;
	integer seed = 32'h90896df5;
	// Clock
	always #2.5 ref_clk_in = ~ref_clk_in;
	tpio_gpio i_tpio_gpio (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsz), .hready_in(hready), .hwdata_in(hwdata),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .p0_pin_in(pin[4:0]), .p0_pin_out(dout[4:0]),
		.p0_pin_oe_out(oe[4:0]), .p1_pin_in(pin[12:5]), .p1_pin_out(dout[12:5]), .p1_pin_oe_out(oe[12:5]),
		.p3_pin_in(pin[20:13]), .p3_pin_out(dout[20:13]), .p3_pin_oe_out(oe[20:13]), .pwm_wave_in(pwm),
		.ext_irq0_input_out(irq0), .ext_irq1_input_out(irq1), .timer0_count_input_out(t0),
		.adc_enable_out(adc_en), .adc_select_out(adc_sel));
	tpio_board i_tpio_board (.ref_clk_in(ref_clk_in), .dev_oe_in(oe), .dev_out_in(dout), .ext_en_in(ext_en),
		.ext_val_in(ext_val), .pin_out(pin));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One AHB-Lite single word transfer
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge ref_clk_in);
		while (hready !== 1'b1) @(posedge ref_clk_in);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge ref_clk_in);
		while (hready !== 1'b1) @(posedge ref_clk_in);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	// Pin level: latch zero pulls low, otherwise board driver or pull-up
	function automatic logic [20:0] exp_pin(input logic [20:0] lt, input logic [20:0] en, input logic [20:0] v);
		return lt & (~en | v);
	endfunction
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		logic [7:0] x;
		logic w;
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge ref_clk_in);
		// Reset values and an unmapped place
		rd_chk(OFS_P0_LATCH, 32'h1f);
		rd_chk(OFS_P1_LATCH, 32'hff);
		rd_chk(OFS_P3_LATCH, 32'hff);
		rd_chk(OFS_CTRL, 32'h0);
		wr(8'h1c, 32'hffffffff);
		rd_chk(8'h1c, 32'h0);
		// A byte-sized write is refused
		hsz <= 3'h0;
		wr(OFS_P3_LATCH, 32'h0);
		hsz <= HSIZE_WORD;
		rd_chk(OFS_P3_LATCH, 32'hff);
		chk(oe, 32'h0);
		// Random latches against board drivers, corner case all low first
		for (int k = 0; k < 10; k++) begin
			l = (k == 0) ? 21'h0 : 21'($random(seed));
			ext_en <= 21'($random(seed)) | 21'h7;
			ext_val <= 21'($random(seed));
			wr(OFS_P0_LATCH, {27'h0, l[4:0]});
			wr(OFS_P1_LATCH, {24'h0, l[12:5]});
			wr(OFS_P3_LATCH, {24'h0, l[20:13]});
			repeat (6) @(posedge ref_clk_in);
			e = exp_pin(l, ext_en, ext_val);
			chk(oe, {11'h0, ~l});
			chk(dout, 32'h0);
			chk({t0, irq1, irq0}, e[12:10]);
			rd_chk(OFS_P0_PINS, e[4:0]);
			rd_chk(OFS_P1_PINS, e[12:5]);
			rd_chk(OFS_P3_PINS, e[20:13]);
			rd_chk(OFS_P3_LATCH, l[20:13]);
		end
		// PWM wave replaces the latch on bit 4
		wr(OFS_CTRL, 32'h1);
		repeat (2) @(posedge ref_clk_in);
		for (int k = 0; k < 16; k++) begin
			w = 1'($random(seed));
			pwm <= w;
			repeat (2) @(posedge ref_clk_in);
			chk({oe[4], dout[4], pin[4]}, {1'b1, w, w});
		end
		wr(OFS_CTRL, 32'h0);
		repeat (2) @(posedge ref_clk_in);
		chk({oe[4], dout[4]}, {~l[4], 1'b0});
		// Converter on: analog pins released, selected channel reads zero
		ext_en <= '1;
		ext_val <= 21'($random(seed));
		wr(OFS_P1_LATCH, 32'h0);
		for (int s = 0; s < 8; s++) begin
			wr(OFS_CTRL, {27'h0, 3'(s), 2'b10});
			repeat (5) @(posedge ref_clk_in);
			x = {3'b000, ext_val[9:5]};
			if (s < 5) x[s] = 1'b0;
			chk(oe[12:5], 32'he0);
			chk({adc_en, adc_sel}, {1'b1, 3'(s)});
			rd_chk(OFS_P1_PINS, x);
		end
		wr(OFS_CTRL, 32'h0);
		repeat (2) @(posedge ref_clk_in);
		chk(oe[12:5], 32'hff);
		// Reset in mid-run restores latches, control and pin drive
		wr(OFS_CTRL, 32'h1f);
		wr(OFS_P3_LATCH, 32'h0);
		sys_rst_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		@(posedge ref_clk_in);
		chk({adc_sel, adc_en, oe}, 32'h0);
		rd_chk(OFS_P3_LATCH, 32'hff);
		rd_chk(OFS_P1_LATCH, 32'hff);
		rd_chk(OFS_CTRL, 32'h0);
		test_done();
	end
endmodule
